// ### design/cira_bank.v
module cira_bank #(
   parameter COUNT = 8,
   parameter IDX_W = 3,
   parameter [8*COUNT-1:0] DEFAULTS = {8*COUNT{1'b0}}
) (
   input wire core_clk,
   input wire sys_rst,
   input wire soft_rst,
   input wire wr_en,
   input wire [IDX_W-1:0] idx,
   input wire [7:0] wr_data,
   output wire [7:0] rd_data
);
   reg [8*COUNT-1:0] mem_q;
   integer i;

   assign rd_data = mem_q[idx*8 +: 8];

   always @(posedge core_clk) begin
      if (sys_rst || soft_rst) begin
         mem_q <= DEFAULTS;
      end else if (wr_en) begin
         for (i = 0; i < COUNT; i = i + 1) begin
            if (idx == i[IDX_W-1:0]) begin
               mem_q[i*8 +: 8] <= wr_data;
            end
         end
      end
   end
endmodule // cira_bank

// ### design/cira_regs.vh
// Summary of operation
// - each local register has a copy per data channel and per clock channel
// - channel index bits steer local accesses: A bit 0, B bit 1, frame 4, data 5
// - with every index bit set, one write lands in all four copies
// - with every index bit set, a read returns the channel A copy
// - global registers ignore the channel index register completely
// - port configuration reads bits 7 and 0 as 0, bits 4 and 3 as 1
// - writing 1 to port configuration bit 5 starts a soft reset of user registers
// - soft reset bit 2 clears itself when the soft reset completes
// - channel index resets to 0x33, both channel pairs selected
`ifndef CIRA_REGS_VH
`define CIRA_REGS_VH
`define CIRA_ADDR_PORT_CFG 13'h0000
`define CIRA_ADDR_CHAN_IDX 13'h0005
`define CIRA_ADDR_LOC_BASE 13'h0008
`define CIRA_ADDR_GLB_BASE 13'h0010
`define CIRA_PORT_CFG_FIXED 8'h18
`define CIRA_PORT_CFG_SRST_HI 5
`define CIRA_PORT_CFG_SRST_LO 2
`define CIRA_PORT_CFG_LSB_HI 6
`define CIRA_PORT_CFG_LSB_LO 1
`define CIRA_CHAN_IDX_RESET 8'h33
`define CIRA_CHAN_IDX_MASK 8'h33
`define CIRA_CHAN_A_BIT 0
`define CIRA_CHAN_B_BIT 1
`define CIRA_CHAN_FRAME_BIT 4
`define CIRA_CHAN_DATA_BIT 5
`endif

// ### design/cira_top.v
`include "cira_regs.vh"
module cira_top #(
   parameter LOC_COUNT = 8,
   parameter GLB_COUNT = 8,
   parameter IDX_W = 3,
   parameter [8*LOC_COUNT-1:0] LOC_DEFAULTS = {8*LOC_COUNT{1'b0}},
   parameter [8*GLB_COUNT-1:0] GLB_DEFAULTS = {8*GLB_COUNT{1'b0}}
) (
   input wire core_clk,
   input wire sys_rst,
   input wire acc_wr,
   input wire acc_rd,
   input wire [12:0] acc_addr,
   input wire [7:0] acc_wdata,
   output reg [7:0] acc_rdata_q,
   output reg acc_rvalid_q,
   output reg lsb_first_q,
   output reg soft_rst_q,
   output reg [7:0] chan_idx_q
);
   reg [7:0] chan_idx_d;
   reg lsb_first_d;
   reg soft_rst_d;
   reg [7:0] acc_rdata_d;
   reg [8*GLB_COUNT-1:0] glb_q;
   reg [8*GLB_COUNT-1:0] glb_d;
   reg [3:0] copy_wr;
   wire [7:0] copy_rd [0:3];
   wire [IDX_W-1:0] loc_idx;
   wire [IDX_W-1:0] glb_idx;
   wire loc_hit;
   wire glb_hit;
   wire [3:0] chan_sel;
   wire [12:0] loc_off;
   wire [12:0] glb_off;
   wire wr_port_cfg;
   wire wr_chan_idx;
   wire wr_glb;
   wire wr_loc;
   wire sel_a;
   wire sel_b;
   wire sel_frame;
   wire sel_data;
   integer k;

   function in_window;
      input [12:0] addr;
      input [12:0] base;
      input integer count;
      begin
         in_window = (addr >= base) && ({19'h0, addr} < {19'h0, base} + count);
      end
   endfunction

   assign loc_hit = in_window(acc_addr, `CIRA_ADDR_LOC_BASE, LOC_COUNT);
   assign glb_hit = in_window(acc_addr, `CIRA_ADDR_GLB_BASE, GLB_COUNT);
   // offsets keep all 13 bits before the cut, so a base off the index grid still works
   assign loc_off = acc_addr - `CIRA_ADDR_LOC_BASE;
   assign glb_off = acc_addr - `CIRA_ADDR_GLB_BASE;
   assign loc_idx = loc_off[IDX_W-1:0];
   assign glb_idx = glb_off[IDX_W-1:0];
   assign wr_port_cfg = acc_wr && (acc_addr == `CIRA_ADDR_PORT_CFG);
   assign wr_chan_idx = acc_wr && (acc_addr == `CIRA_ADDR_CHAN_IDX);
   assign wr_glb = acc_wr && glb_hit;
   assign wr_loc = acc_wr && loc_hit;

   assign sel_a = chan_idx_q[`CIRA_CHAN_A_BIT];
   assign sel_b = chan_idx_q[`CIRA_CHAN_B_BIT];
   assign sel_frame = chan_idx_q[`CIRA_CHAN_FRAME_BIT];
   assign sel_data = chan_idx_q[`CIRA_CHAN_DATA_BIT];
   // copy order: A, B, frame clock, data clock
   assign chan_sel = {sel_data, sel_frame, sel_b, sel_a};

   always @* begin
      copy_wr = wr_loc ? chan_sel : 4'h0;
   end

   genvar c;
   generate
      for (c = 0; c < 4; c = c + 1) begin : g_copy
         cira_bank #(
            .COUNT(LOC_COUNT),
            .IDX_W(IDX_W),
            .DEFAULTS(LOC_DEFAULTS)
         ) u_bank (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .soft_rst(soft_rst_q),
            .wr_en(copy_wr[c]),
            .idx(loc_idx),
            .wr_data(acc_wdata),
            .rd_data(copy_rd[c])
         );
      end
   endgenerate

   // soft reset wins over a write in its own cycle, so no register sees both
   always @* begin
      chan_idx_d = chan_idx_q;
      if (soft_rst_q) begin
         chan_idx_d = `CIRA_CHAN_IDX_RESET;
      end else if (wr_chan_idx) begin
         // unused index bits are never stored and read back as 0
         chan_idx_d = acc_wdata & `CIRA_CHAN_IDX_MASK;
      end
   end

   always @* begin
      lsb_first_d = lsb_first_q;
      if (soft_rst_q) begin
         lsb_first_d = 1'b0;
      end else if (wr_port_cfg) begin
         // mirrored nibbles: either copy of a bit acts, so bit order never matters
         lsb_first_d = acc_wdata[`CIRA_PORT_CFG_LSB_HI] | acc_wdata[`CIRA_PORT_CFG_LSB_LO];
      end
   end

   always @* begin
      soft_rst_d = 1'b0;
      if (!soft_rst_q && wr_port_cfg) begin
         soft_rst_d = acc_wdata[`CIRA_PORT_CFG_SRST_HI] | acc_wdata[`CIRA_PORT_CFG_SRST_LO];
      end
   end

   always @* begin
      glb_d = glb_q;
      if (soft_rst_q) begin
         glb_d = GLB_DEFAULTS;
      end else if (wr_glb) begin
         for (k = 0; k < GLB_COUNT; k = k + 1) begin
            if (glb_idx == k[IDX_W-1:0]) begin
               glb_d[k*8 +: 8] = acc_wdata;
            end
         end
      end
   end

   always @* begin
      acc_rdata_d = 8'h00;
      if (acc_addr == `CIRA_ADDR_PORT_CFG) begin
         acc_rdata_d = `CIRA_PORT_CFG_FIXED;
         acc_rdata_d[`CIRA_PORT_CFG_LSB_HI] = lsb_first_q;
         acc_rdata_d[`CIRA_PORT_CFG_LSB_LO] = lsb_first_q;
         acc_rdata_d[`CIRA_PORT_CFG_SRST_HI] = soft_rst_q;
         acc_rdata_d[`CIRA_PORT_CFG_SRST_LO] = soft_rst_q;
      end else if (acc_addr == `CIRA_ADDR_CHAN_IDX) begin
         acc_rdata_d = chan_idx_q;
      end else if (loc_hit) begin
         if (chan_sel[0]) begin
            acc_rdata_d = copy_rd[0];
         end else if (chan_sel[1]) begin
            acc_rdata_d = copy_rd[1];
         end else if (chan_sel[2]) begin
            acc_rdata_d = copy_rd[2];
         end else if (chan_sel[3]) begin
            acc_rdata_d = copy_rd[3];
         end
      end else if (glb_hit) begin
         acc_rdata_d = glb_q[glb_idx*8 +: 8];
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         chan_idx_q <= `CIRA_CHAN_IDX_RESET;
      end else begin
         chan_idx_q <= chan_idx_d;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         lsb_first_q <= 1'b0;
      end else begin
         lsb_first_q <= lsb_first_d;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= soft_rst_d;
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         glb_q <= GLB_DEFAULTS;
      end else begin
         glb_q <= glb_d;
      end
   end

   // answer pulse trails every read strobe by exactly one cycle
   always @(posedge core_clk) begin
      if (sys_rst) begin
         acc_rvalid_q <= 1'b0;
      end else begin
         acc_rvalid_q <= acc_rd;
      end
   end

   // read data holds between reads, so a slow framer may shift it out late;
   // soft reset leaves it alone to keep an answer in flight intact
   always @(posedge core_clk) begin
      if (sys_rst) begin
         acc_rdata_q <= 8'h00;
      end else if (acc_rd) begin
         acc_rdata_q <= acc_rdata_d;
      end
   end
endmodule // cira_top

// ### dv/cira_chk.sv
module cira_chk (
   input logic core_clk,
   input logic sys_rst,
   input logic acc_wr,
   input logic acc_rd,
   input logic [12:0] acc_addr,
   input logic [7:0] acc_wdata,
   input logic [7:0] acc_rdata_q,
   input logic acc_rvalid_q,
   input logic lsb_first_q,
   input logic soft_rst_q,
   input logic [7:0] chan_idx_q
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_rd_answer: assert property (acc_rd |=> acc_rvalid_q)
      else $error("read not answered");
   a_rvalid_pulse: assert property (!acc_rd |=> !acc_rvalid_q)
      else $error("spurious read answer");
   a_idx_reset: assert property ($fell(sys_rst) |-> chan_idx_q == 8'h33)
      else $error("bad index reset");
   a_idx_write: assert property (acc_wr && acc_addr == 13'h5 && !soft_rst_q
      |=> chan_idx_q == ($past(acc_wdata) & 8'h33)) else $error("bad index write");
   a_cfg_fixed: assert property (acc_rd && acc_addr == 13'h0
      |=> (acc_rdata_q & 8'h99) == 8'h18) else $error("bad fixed bits");
   a_srst_pulse: assert property (acc_wr && acc_addr == 13'h0 && acc_wdata[5] && !soft_rst_q
      |=> soft_rst_q ##1 !soft_rst_q) else $error("bad soft reset pulse");
   a_srst_idx: assert property (soft_rst_q |=> chan_idx_q == 8'h33 && !lsb_first_q)
      else $error("soft reset missed a register");
   a_srst_clear: assert property (soft_rst_q ##1 (acc_rd && acc_addr == 13'h0)
      |=> !acc_rdata_q[2]) else $error("soft reset bit stuck");
endmodule // cira_chk
bind cira_top cira_chk cira_chk_i (.*);

// ### dv/cira_host.sv
module cira_host (
   input logic core_clk,
   input logic [7:0] acc_rdata_q,
   input logic acc_rvalid_q,
   output logic acc_wr,
   output logic acc_rd,
   output logic [12:0] acc_addr,
   output logic [7:0] acc_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      acc_wr = 1'b0;
      acc_rd = 1'b0;
      acc_addr = 13'h0;
      acc_wdata = 8'h0;
   end
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {acc_wr, acc_addr, acc_wdata} = {1'b1, a, d};
      @(negedge core_clk);
      // released lines flip so a stale value never looks valid
      {acc_wr, acc_addr, acc_wdata} = {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [12:0] a, output logic [7:0] q, output logic v);
      @(negedge core_clk);
      {acc_rd, acc_addr} = {1'b1, a};
      @(negedge core_clk);
      // answer settled half a cycle after the taking edge
      {q, v} = {acc_rdata_q, acc_rvalid_q};
      {acc_rd, acc_addr} = {1'b0, ~a};
   endtask
endmodule // cira_host

// ### dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic acc_wr, acc_rd, acc_rvalid_q, lsb_first_q, soft_rst_q, v, lsb_m;
   logic [12:0] acc_addr, a;
   logic [7:0] acc_wdata, acc_rdata_q, chan_idx_q, idx_m, q;
   logic [7:0] loc [0:3][0:7];
   logic [7:0] glb [0:7];
   int error_cnt = 0;
   int checks_done = 0;
   always #12.5 core_clk = ~core_clk;
   cira_top cira_top_i (.*);
   cira_host cira_host_i (.*);
   // copies A, B, frame, data sit on index bits 0, 1, 4, 5
   function automatic int copy_bit(int c);
      return c < 2 ? c : c + 2;
   endfunction
   function automatic logic [7:0] exp_rd(logic [12:0] x);
      if (x == 13'h0) return lsb_m ? 8'h5A : 8'h18;
      if (x == 13'h5) return idx_m;
      if (x inside {[13'h8:13'hF]})
         for (int c = 0; c < 4; c++) if (idx_m[copy_bit(c)]) return loc[c][x[2:0]];
      if (x inside {[13'h10:13'h17]}) return glb[x[2:0]];
      return 8'h00;
   endfunction
   task automatic mwr(logic [12:0] x, logic [7:0] d);
      cira_host_i.wr(x, d);
      if (x == 13'h0) lsb_m = d[6] | d[1];
      if (x == 13'h0 && (d[5] | d[2])) rst_m();
      if (x == 13'h5) idx_m = d & 8'h33;
      if (x inside {[13'h8:13'hF]})
         for (int c = 0; c < 4; c++) if (idx_m[copy_bit(c)]) loc[c][x[2:0]] = d;
      if (x inside {[13'h10:13'h17]}) glb[x[2:0]] = d;
   endtask
   task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk(logic [12:0] x);
      cira_host_i.rd(x, q, v);
      cmp("read data", exp_rd(x), q);
      cmp("read valid", 8'h01, {7'h00, v});
      cmp("channel index", idx_m, chan_idx_q);
      cmp("lsb first", {7'h00, lsb_m}, {7'h00, lsb_first_q});
   endtask
   task automatic rst_m;
      idx_m = 8'h33;
      lsb_m = 1'b0;
      loc = '{default: 8'h00};
      glb = '{default: 8'h00};
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      rst_m();
      void'($urandom(32'h687E));
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      chk(13'h0);
      chk(13'h5);
      mwr(13'hB, 8'hA5);
      for (int c = 0; c < 8; c++) begin
         mwr(13'h5, 8'h01 << copy_bit(c % 4));
         if (c < 4) mwr(13'hC, 8'(c + 1));
         chk(13'hB + 13'(c / 4));
      end
      mwr(13'h5, 8'h33);
      chk(13'hC);
      mwr(13'h0, 8'h42);
      chk(13'h0);
      repeat (300) begin
         a = 13'h5 + 13'($urandom_range(0, 19));
         if ($urandom_range(0, 1)) mwr(a, a == 13'h5 ? 8'($urandom) & 8'h33 : 8'($urandom));
         else begin
            if (idx_m == 8'h00) mwr(13'h5, 8'h01);
            chk(a);
         end
      end
      mwr(13'h0, 8'h24);
      chk(13'h0);
      chk(13'h8);
      complete_run();
   end
   initial begin
      #100us;
      error_cnt++;
      complete_run();
   end
endmodule // tb_top
